/* File: rtl/lhc_map.svh */
`ifndef LHC_MAP_SVH
`define LHC_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define LHC_OFS_SET        12'h050
`define LHC_OFS_CLR        12'h054
`define LHC_OFS_STAT       12'h058

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LHC_BIT_SWAP       30
`define LHC_BIT_OWN        23
`define LHC_BIT_ENH        22
`define LHC_BIT_LPS        19
`define LHC_BIT_POST       18
`define LHC_BIT_ATTACH     17
`define LHC_BIT_REINIT     16

// writable and readable bit masks
`define LHC_RW_MASK        32'h40CF_0000
`define LHC_RD_MASK        32'h40CF_0000

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define LHC_RST_SWAP       1'b0
`define LHC_RST_POST       1'b0
`define LHC_REINIT_CYCLES  8'h10

`endif

/* File: rtl/lhc_pkg.sv */
package lhc_pkg;

    typedef enum logic [1:0] {
        LHC_IDLE,
        LHC_REINIT,
        LHC_LOAD
    } lhc_state_t;

endpackage : lhc_pkg

/* File: rtl/lhc_link_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lhc_map.svh"

// Overview of operation
// - control flags reachable at a set address and a separate clear address
// - reading either address returns the shared flag value
// - reserved bits 31, 29-24, 21-20, 15-0 always read zero
// - bit 30 selects byte swapping on DMA and outside physical accesses
// - ownership bit 23 only read and cleared by software, loaded from EEPROM
// - link power status zero blocks all link-to-PHY traffic
// - bit 18 enables write posting
// - bus attach cleared by hardware or software reset
// - detached node receives, processes and transmits no packets
// - self reinit resets state, flushes FIFOs, restores register resets except ownership bit 23
// - self reinit leaves bus-interface configuration untouched
// - self reinit bit reads one while in progress, then clears itself
module lhc_link_ctrl
    import lhc_pkg::*;
#(
    parameter logic [7:0] REINIT_CYCLES = `LHC_REINIT_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // eeprom preload of ownership flag
    input  wire logic        eeprom_load_valid,
    input  wire logic        eeprom_own_value,
    // link-side controls
    output logic             dma_swap_select,
    output logic             enhancement_ownership_flag,
    output logic             enhanced_feature_use,
    output logic             link_power_status,
    output logic             write_posting_on,
    output logic             bus_attach,
    output logic             self_reinit,
    output logic             phy_comm_allow,
    output logic             pkt_rx_allow,
    output logic             pkt_tx_allow,
    output logic             fifo_flush,
    output logic             state_reset
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic        acc     = psel & penable;
    wire logic        hit_set = (paddr == `LHC_OFS_SET);
    wire logic        hit_clr = (paddr == `LHC_OFS_CLR);
    wire logic        hit_sta = (paddr == `LHC_OFS_STAT);
    wire logic        mapped  = hit_set | hit_clr | hit_sta;
    wire logic        wr_set  = acc & pwrite & hit_set;
    wire logic        wr_clr  = acc & pwrite & hit_clr;
    wire logic [31:0] set_m   = wr_set ? (pwdata & `LHC_RW_MASK) : 32'h0000_0000;
    wire logic [31:0] clr_m   = wr_clr ? pwdata : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    logic       swap_r, own_r, enh_r, lps_r, post_r, attach_r;
    logic       swap_nxt, own_nxt, enh_nxt, lps_nxt, post_nxt, attach_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic       eeprom_seen_r;
    lhc_state_t state_r, state_nxt;

    wire logic busy      = (state_r == LHC_REINIT);
    wire logic start_rst = set_m[`LHC_BIT_REINIT] & ~busy;

    // a write colliding with self reinit start loses: restore wins
    always_comb begin
        swap_nxt   = (swap_r   | set_m[`LHC_BIT_SWAP])   & ~clr_m[`LHC_BIT_SWAP];
        own_nxt    = own_r & ~clr_m[`LHC_BIT_OWN];
        enh_nxt    = (enh_r    | set_m[`LHC_BIT_ENH])    & ~clr_m[`LHC_BIT_ENH];
        lps_nxt    = (lps_r    | set_m[`LHC_BIT_LPS])    & ~clr_m[`LHC_BIT_LPS];
        post_nxt   = (post_r   | set_m[`LHC_BIT_POST])   & ~clr_m[`LHC_BIT_POST];
        attach_nxt = (attach_r | set_m[`LHC_BIT_ATTACH]) & ~clr_m[`LHC_BIT_ATTACH];
        if (eeprom_load_valid && !eeprom_seen_r) begin
            own_nxt = eeprom_own_value;
        end
        if (start_rst || busy) begin
            swap_nxt   = `LHC_RST_SWAP;
            enh_nxt    = 1'b0;
            lps_nxt    = 1'b0;
            post_nxt   = `LHC_RST_POST;
            attach_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // self reinit sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            LHC_IDLE: begin
                if (start_rst) begin
                    state_nxt = LHC_REINIT;
                    cnt_nxt   = REINIT_CYCLES;
                end
            end
            LHC_REINIT: begin
                if (cnt_r <= 8'h01) begin
                    state_nxt = LHC_LOAD;
                    cnt_nxt   = 8'h00;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            LHC_LOAD: begin
                state_nxt = LHC_IDLE;
            end
            default: begin
                state_nxt = LHC_IDLE;
                cnt_nxt   = 8'h00;
            end
        endcase
    end

    // ownership flag survives self reinit: only hard reset, clear-address writes and a first EEPROM load of zero clear it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            swap_r        <= 1'b0;
            own_r         <= 1'b0;
            enh_r         <= 1'b0;
            lps_r         <= 1'b0;
            post_r        <= 1'b0;
            attach_r      <= 1'b0;
            eeprom_seen_r <= 1'b0;
            cnt_r         <= 8'h00;
            state_r       <= LHC_IDLE;
        end else begin
            swap_r        <= swap_nxt;
            own_r         <= own_nxt;
            enh_r         <= enh_nxt;
            lps_r         <= lps_nxt;
            post_r        <= post_nxt;
            attach_r      <= attach_nxt;
            eeprom_seen_r <= eeprom_seen_r | eeprom_load_valid;
            cnt_r         <= cnt_nxt;
            state_r       <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] flags;
    always_comb begin
        flags                  = 32'h0000_0000;
        flags[`LHC_BIT_SWAP]   = swap_r;
        flags[`LHC_BIT_OWN]    = own_r;
        flags[`LHC_BIT_ENH]    = enh_r;
        flags[`LHC_BIT_LPS]    = lps_r;
        flags[`LHC_BIT_POST]   = post_r;
        flags[`LHC_BIT_ATTACH] = attach_r;
        flags[`LHC_BIT_REINIT] = busy;
        flags                  = flags & `LHC_RD_MASK;
    end

    wire logic [31:0] rd_mux = (hit_set | hit_clr) ? flags :
                               hit_sta ? {30'h0000_0000, eeprom_seen_r, busy} : 32'h0000_0000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // link-side controls
    // ------------------------------------------------------------
    // apb config is outside this reset domain, so reinit never touches it
    assign dma_swap_select            = swap_r;
    assign enhancement_ownership_flag = own_r;
    assign enhanced_feature_use       = enh_r;
    assign link_power_status          = lps_r;
    assign write_posting_on           = post_r;
    assign bus_attach                 = attach_r;
    assign self_reinit                = busy;
    assign phy_comm_allow             = lps_r & ~busy;
    assign pkt_rx_allow               = attach_r & lps_r & ~busy;
    assign pkt_tx_allow               = attach_r & lps_r & ~busy;
    assign fifo_flush                 = busy;
    assign state_reset                = busy;

endmodule : lhc_link_ctrl

`default_nettype wire

/* File: tb/lhc_link_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------
// link control checks
// ----------------
module lhc_chk #(parameter logic [7:0] REINIT_CYCLES = 8'h10) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // apb and eeprom load
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        eeprom_load_valid,
    // link side
    input wire logic        dma_swap_select,
    input wire logic        enhancement_ownership_flag,
    input wire logic        enhanced_feature_use,
    input wire logic        link_power_status,
    input wire logic        write_posting_on,
    input wire logic        bus_attach,
    input wire logic        self_reinit,
    input wire logic        phy_comm_allow,
    input wire logic        pkt_rx_allow,
    input wire logic        pkt_tx_allow,
    input wire logic        fifo_flush,
    input wire logic        state_reset
);
    logic [7:0]  run_r;
    wire         acc    = psel && penable;
    wire         wr_set = acc && pwrite && paddr == 12'h050 && !pwdata[16] && !self_reinit;
    // a same-cycle first eeprom load wins over a clear, so leave it out
    wire         wr_clr = acc && pwrite && paddr == 12'h054 && !self_reinit && !eeprom_load_valid;
    wire         rd_go  = psel && !penable && !pwrite && paddr[11:3] == 9'h00A;
    wire  [31:0] flags  = {1'b0, dma_swap_select, 6'h00, enhancement_ownership_flag, enhanced_feature_use,
                           2'h0, link_power_status, write_posting_on, bus_attach, 17'h00000};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) run_r <= 8'h00;
        else run_r <= self_reinit ? run_r + 8'h01 : 8'h00;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence go_reinit; acc && pwrite && paddr == 12'h050 && pwdata[16] && !self_reinit; endsequence
    sequence held_clear; self_reinit && !bus_attach && !write_posting_on && !dma_swap_select; endsequence
    set_bits_a:
        assert property (wr_set |=> (($past(pwdata) & 32'h404E_0000) & ~flags) == 32'h0) else $error("set lost");
    clr_bits_a:
        assert property (wr_clr |=> (($past(pwdata) & 32'h40CE_0000) & flags) == 32'h0) else $error("clear lost");
    own_set_a:
        assert property (wr_set && !enhancement_ownership_flag && !eeprom_load_valid
                         |=> !enhancement_ownership_flag) else $error("ownership set by write");
    read_back_a:
        assert property (rd_go |=> (prdata & 32'hFFFE_FFFF) == $past(flags)) else $error("bad read value");
    map_err_a:
        assert property (acc && paddr != 12'h050 && paddr != 12'h054 && paddr != 12'h058 |-> pslverr)
            else $error("no error on unmapped");
    phy_gate_a:
        assert property (phy_comm_allow |-> link_power_status && !self_reinit) else $error("phy not gated");
    attach_gate_a:
        assert property (pkt_rx_allow || pkt_tx_allow |-> bus_attach && link_power_status)
            else $error("packets while detached");
    reinit_a:
        assert property (go_reinit |=> held_clear) else $error("reinit did not clear");
    reinit_len_a:
        assert property ($fell(self_reinit) |-> run_r == REINIT_CYCLES) else $error("reinit length");
    flush_tie_a:
        assert property (fifo_flush == self_reinit && state_reset == self_reinit) else $error("flush not tied");
endmodule : lhc_chk
bind lhc_link_ctrl lhc_chk #(.REINIT_CYCLES(REINIT_CYCLES)) chk_i (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------
// link control bench
// ----------------
module testbench;
    localparam logic [7:0] RC = 8'h04;
    logic        sys_clk, rst, psel, penable, pwrite, eeprom_load_valid, eeprom_own_value, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, m, seed, k;
    logic        pready, pslverr, dma_swap_select, enhancement_ownership_flag, enhanced_feature_use;
    logic        link_power_status, write_posting_on, bus_attach, self_reinit, phy_comm_allow;
    logic        pkt_rx_allow, pkt_tx_allow, fifo_flush, state_reset;
    int          fail_count, comparisons, i;
    lhc_link_ctrl #(.REINIT_CYCLES(RC)) dut (.*);
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one idle edge after each transfer keeps psel from being driven twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        eeprom_load_valid = 1'b0; eeprom_own_value = 1'b0; seed = 32'h6BC604F3;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h050, 32'h0);
        chk(q, 32'h0);
        eeprom_load_valid <= 1'b1; eeprom_own_value <= 1'b1;
        @(posedge sys_clk);
        eeprom_load_valid <= 1'b0;
        m = 32'h0080_0000;
        for (i = 0; i < 40; i++) begin
            seed = nxt(seed);
            // enhancement bit only touched with ownership and attach, posting only while detached
            k = 32'hFFFE_FFFF & ((m[23] && m[17]) ? 32'hFFFF_FFFF : 32'hFFBF_FFFF);
            k = k & (m[17] ? 32'hFFFB_FFFF : 32'hFFFF_FFFF);
            apb(1'b1, {9'h00A, seed[0], 2'h0}, seed & k);
            m = seed[0] ? m & ~(seed & k & 32'h40CE_0000) : m | (seed & k & 32'h404E_0000);
            apb(1'b0, {9'h00A, ~seed[0], 2'h0}, 32'h0);
            chk(q, m);
            chk({29'h0, bus_attach, phy_comm_allow, pkt_tx_allow}, {29'h0, m[17], m[19], m[17] & m[19]});
            chk({27'h0, dma_swap_select, enhancement_ownership_flag, enhanced_feature_use, link_power_status,
                 write_posting_on}, {27'h0, m[30], m[23], m[22], m[19], m[18]});
        end
        apb(1'b1, 12'h05C, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h054, 32'h0);
        chk(q, m);
        // attach set only when the system is ready; bus reset is outside this block
        apb(1'b1, 12'h050, 32'h400A_0000);
        m = m | 32'h400A_0000;
        apb(1'b1, 12'h050, 32'h0001_0000);
        apb(1'b0, 12'h054, 32'h0);
        chk(q, (m & 32'h0080_0000) | 32'h0001_0000);
        for (i = 0; i < 20 && q[16] !== 1'b0; i++) apb(1'b0, 12'h050, 32'h0);
        chk(q, m & 32'h0080_0000);
        apb(1'b1, 12'h050, 32'h000A_0000);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h050, 32'h0);
        chk(q, 32'h0);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
